// ===== hdl/tsc_commit_timer.sv
/*
  commit timer for the control byte: runs a fixed number of cycles
  after start; assumes start only arrives while idle.
*/
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_commit_timer
  import tsc_pkg::*;
#(
  parameter int unsigned CYC = `TSC_BUSY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned CW = $clog2(CYC + 1);
  tsc_cmt_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    unique case (state_q)
      TSC_CMT_IDLE: begin
        if (start_i) begin
          state_d = TSC_CMT_RUN;
          cnt_d = CW'(1);
        end
      end
      TSC_CMT_RUN: begin
        // never longer than the worst-case commit time
        if (cnt_q >= CW'(CYC)) begin
          state_d = TSC_CMT_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TSC_CMT_IDLE;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy_o = (state_q == TSC_CMT_RUN);
  assign done_o = done_q;
endmodule : tsc_commit_timer

// ===== hdl/tsc_period_timer.sv
/*
  measurement scheduler: decodes the period field into start pulses;
  assumes meas_busy_i is high while a conversion is running.
*/
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_period_timer
  import tsc_pkg::*;
#(
  parameter int unsigned SEC_CYC = `TSC_SEC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] period_i,
  input wire logic meas_busy_i,
  output logic start_o
);
  localparam int unsigned PW = $clog2(SEC_CYC + 1);
  tsc_mode_t mode;
  logic [PW-1:0] pre_q, pre_d;
  logic [9:0] sec_q, sec_d;
  logic [9:0] limit;
  logic [3:0] expo;
  logic start_q, start_d;
  logic sec_tick;

  always_comb begin
    expo = `TSC_PER_EXP_BASE + {1'b0, period_i};
    limit = 10'((11'h001 << expo) - 11'h001);
    if (period_i == `TSC_PER_OFF) begin
      mode = TSC_MODE_OFF;
    end else if (period_i == `TSC_PER_CONT) begin
      mode = TSC_MODE_CONT;
    end else begin
      mode = TSC_MODE_TIMED;
    end
  end

  always_comb begin
    sec_tick = (pre_q >= PW'(SEC_CYC - 1));
    pre_d = sec_tick ? '0 : pre_q + PW'(1);
    sec_d = sec_q;
    start_d = 1'b0;
    unique case (mode)
      TSC_MODE_OFF: begin
        sec_d = '0;
      end
      TSC_MODE_TIMED: begin
        // period of 2^(3+value) seconds
        if (sec_tick) begin
          if (sec_q >= limit) begin
            sec_d = '0;
            start_d = 1'b1;
          end else begin
            sec_d = sec_q + 10'h001;
          end
        end
      end
      TSC_MODE_CONT: begin
        // restart as soon as the previous conversion is over
        sec_d = '0;
        start_d = !meas_busy_i && !start_q;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
      sec_q <= '0;
      start_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      sec_q <= sec_d;
      start_q <= start_d;
    end
  end

  assign start_o = start_q;
endmodule : tsc_period_timer

// ===== hdl/tsc_regs.sv
/*
  temperature sense configuration and status registers behind a
  classic wishbone slave, 32-bit data, word addressed by adr_i[15:2].
  assumes the conversion logic supplies the raw reading and a store
  strobe for the 22 degree calibration point.
*/
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_regs
  import tsc_pkg::*;
#(
  parameter int unsigned BUSY_CYC = `TSC_BUSY_CYC,
  parameter int unsigned SEC_CYC = `TSC_SEC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ref_store_i,
  input wire logic [10:0] raw_temp_result_i,
  input wire logic meas_busy_i,
  output logic [11:0] quad_comp_coeff_b_o,
  output logic [11:0] quad_comp_coeff_c_o,
  output logic [2:0] meas_period_o,
  output logic battery_measure_enable_o,
  output logic battery_select_o,
  output logic meas_start_o,
  output logic battery_meas_start_o
);
  logic [13:0] idx;
  logic req;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic wr_ok;
  logic hit_ref, hit_b, hit_c, hit_ctl;
  logic [11:0] coeff_b_q, coeff_b_d;
  logic [11:0] coeff_c_q, coeff_c_d;
  logic [12:0] ref_q, ref_d;
  logic [7:0] pend_q, pend_d;
  logic [7:0] live_q, live_d;
  logic busy_q, busy_d;
  logic ctl_wr;
  logic cmt_done;
  logic [7:0] ctl_view;
  logic start;

  // address decode
  always_comb begin
    idx = adr_i[15:2];
    req = cyc_i && stb_i;
    hit_ref = (idx == `TSC_IDX_REF);
    hit_b = (idx == `TSC_IDX_COEFF_B);
    hit_c = (idx == `TSC_IDX_COEFF_C);
    hit_ctl = (idx == `TSC_IDX_CTRL);
  end

  // writes land on the edge where the master sees ack
  always_comb begin
    wr_ok = req && we_i && ack_q;
    ctl_wr = wr_ok && hit_ctl && sel_i[0] && !busy_q;
  end

  // control byte as software reads it back
  always_comb begin
    ctl_view = pend_q;
    ctl_view[`TSC_CTL_BUSY_BIT] = busy_q;
    ctl_view[6:5] = 2'h0;
  end

  // bus handshake and read data
  always_comb begin
    ack_d = req && !ack_q;
    dat_d = dat_q;
    if (req && !ack_q) begin
      dat_d = 32'h0000_0000;
      if (!we_i) begin
        if (hit_ref) begin
          dat_d[12:0] = ref_q;
        end else if (hit_b) begin
          dat_d[11:0] = coeff_b_q;
        end else if (hit_c) begin
          dat_d[11:0] = coeff_c_q;
        end else if (hit_ctl) begin
          dat_d[7:0] = ctl_view;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // coefficient registers, byte lanes honoured
  always_comb begin
    coeff_b_d = coeff_b_q;
    coeff_c_d = coeff_c_q;
    if (wr_ok && hit_b) begin
      if (sel_i[0]) begin
        coeff_b_d[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        coeff_b_d[11:8] = dat_i[11:8];
      end
    end
    if (wr_ok && hit_c) begin
      if (sel_i[0]) begin
        coeff_c_d[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        coeff_c_d[11:8] = dat_i[11:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coeff_b_q <= `TSC_COEFF_RST;
      coeff_c_q <= `TSC_COEFF_RST;
    end else begin
      coeff_b_q <= coeff_b_d;
      coeff_c_q <= coeff_c_d;
    end
  end

  // calibration point capture; bus writes cannot reach it
  always_comb begin
    ref_d = ref_q;
    if (ref_store_i) begin
      ref_d = {2'b00, raw_temp_result_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= `TSC_REF_RST;
    end else begin
      ref_q <= ref_d;
    end
  end

  // control byte: pending copy written by software, live copy
  // applied only once the commit has finished, so the measuring
  // logic never sees a half-updated byte
  always_comb begin
    pend_d = pend_q;
    live_d = live_q;
    busy_d = busy_q;
    if (ctl_wr) begin
      pend_d = dat_i[7:0];
      pend_d[`TSC_CTL_BUSY_BIT] = 1'b0;
      pend_d[6:5] = 2'h0;
      busy_d = 1'b1;
    end else if (cmt_done) begin
      live_d = pend_q;
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= `TSC_CTL_RST;
      live_q <= `TSC_CTL_RST;
      busy_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      live_q <= live_d;
      busy_q <= busy_d;
    end
  end

  tsc_commit_timer #(
    .CYC(BUSY_CYC)
  ) u_commit (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(ctl_wr),
    .busy_o(),
    .done_o(cmt_done)
  );

  tsc_period_timer #(
    .SEC_CYC(SEC_CYC)
  ) u_period (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .period_i(live_q[`TSC_CTL_PER_MSB:`TSC_CTL_PER_LSB]),
    .meas_busy_i(meas_busy_i),
    .start_o(start)
  );

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign quad_comp_coeff_b_o = coeff_b_q;
  assign quad_comp_coeff_c_o = coeff_c_q;
  assign meas_period_o = live_q[`TSC_CTL_PER_MSB:`TSC_CTL_PER_LSB];
  assign battery_measure_enable_o = live_q[`TSC_CTL_BAT_BIT];
  assign battery_select_o = live_q[`TSC_CTL_BSEL_BIT];
  assign meas_start_o = start;
  assign battery_meas_start_o = start && live_q[`TSC_CTL_BAT_BIT];
endmodule : tsc_regs

// ===== inc/tsc_params.svh
/*
  offsets, field positions, reset values and timing counts of the
  temperature sense register bank; assumes a 50 MHz system clock.
*/
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH
// register word indexes, byte address is four times the index
`define TSC_IDX_REF 14'h230A
`define TSC_IDX_COEFF_B 14'h250A
`define TSC_IDX_COEFF_C 14'h289C
`define TSC_IDX_CTRL 14'h28A0
// control byte fields
`define TSC_CTL_PER_LSB 0
`define TSC_CTL_PER_MSB 2
`define TSC_CTL_BUSY_BIT 3
`define TSC_CTL_BAT_BIT 4
`define TSC_CTL_BSEL_BIT 7
`define TSC_PER_OFF 3'h0
`define TSC_PER_CONT 3'h7
`define TSC_PER_EXP_BASE 4'h3
// reset values
`define TSC_COEFF_RST 12'h000
`define TSC_REF_RST 13'h0000
`define TSC_CTL_RST 8'h00
// timing
`define TSC_CLK_HZ 50000000
`define TSC_BUSY_MAX_US 6000
`define TSC_BUSY_CYC (`TSC_BUSY_MAX_US * (`TSC_CLK_HZ / 1000000))
`define TSC_SEC_CYC (`TSC_CLK_HZ)
`endif

// ===== inc/tsc_pkg.sv
/*
  types shared by the temperature sense register bank;
  assumes nothing beyond the params header.
*/
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_MODE_OFF,
    TSC_MODE_TIMED,
    TSC_MODE_CONT
  } tsc_mode_t;
  typedef enum logic {
    TSC_CMT_IDLE,
    TSC_CMT_RUN
  } tsc_cmt_state_t;
endpackage : tsc_pkg

// ===== tb/testbench.sv
/* self-checking bench for tsc_regs over classic wishbone;
   assumes shortened busy and second counts. */
`timescale 1ns/1ps
`include "tsc_params.svh"
module testbench;
  localparam int SEC = 4;
  localparam logic [15:0] A_REF = {`TSC_IDX_REF, 2'b00};
  localparam logic [15:0] A_B = {`TSC_IDX_COEFF_B, 2'b00};
  localparam logic [15:0] A_C = {`TSC_IDX_COEFF_C, 2'b00};
  localparam logic [15:0] A_CTL = {`TSC_IDX_CTRL, 2'b00};
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ref_store_i, meas_busy_i;
  logic battery_measure_enable_o, battery_select_o, meas_start_o, battery_meas_start_o;
  logic [15:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [10:0] raw_temp_result_i;
  logic [11:0] quad_comp_coeff_b_o, quad_comp_coeff_c_o;
  logic [2:0] meas_period_o;
  int n_errors = 0;
  int check_count = 0;
  int n;
  tsc_regs #(.BUSY_CYC(20), .SEC_CYC(SEC)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .ref_store_i, .raw_temp_result_i, .meas_busy_i,
    .quad_comp_coeff_b_o, .quad_comp_coeff_c_o, .meas_period_o, .battery_measure_enable_o,
    .battery_select_o, .meas_start_o, .battery_meas_start_o);
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // request held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hF, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  // software side keeps polling busy before the next control write
  task automatic idle();
    n = 0;
    do begin
      wb(1'b0, A_CTL, 4'hF, 32'h0);
      n++;
    end while (rd[3] !== 1'b0 && n < 50);
    chk("busy clear", 32'h0, {31'h0, rd[3]});
  endtask : idle
  task automatic wait_start(input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (meas_start_o !== 1'b1 && n < lim);
  endtask : wait_start
  initial begin
    {rst_i, cyc_i, stb_i, we_i, ref_store_i, meas_busy_i} = 6'h20;
    {adr_i, sel_i, dat_i, raw_temp_result_i} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ref", A_REF, 32'h0);
    rdchk("coeff_b", A_B, 32'h0);
    rdchk("coeff_c", A_C, 32'h0);
    rdchk("ctrl", A_CTL, 32'h0);
    wb(1'b1, A_B, 4'h3, 32'hFFFF_FFFF);
    rdchk("coeff_b", A_B, 32'hFFF);
    chk("coeff_b_o", 32'hFFF, {20'h0, quad_comp_coeff_b_o});
    wb(1'b1, A_C, 4'h2, 32'h0000_0ABC);
    rdchk("coeff_c", A_C, 32'hA00);
    chk("coeff_c_o", 32'hA00, {20'h0, quad_comp_coeff_c_o});
    wb(1'b1, 16'h0010, 4'hF, 32'h55);
    rdchk("unmapped", 16'h0010, 32'h0);
    chk("coeff_b_o kept", 32'hFFF, {20'h0, quad_comp_coeff_b_o});
    raw_temp_result_i <= 11'h5A5;
    ref_store_i <= 1'b1;
    @(posedge clk_i);
    ref_store_i <= 1'b0;
    rdchk("ref", A_REF, 32'h5A5);
    wb(1'b1, A_CTL, 4'h1, 32'h9F);
    rdchk("ctrl busy", A_CTL, 32'h9F);
    wb(1'b1, A_CTL, 4'h1, 32'h0);
    rdchk("ctrl locked", A_CTL, 32'h9F);
    chk("live ctrl", 32'h0, {29'h0, meas_period_o});
    idle();
    chk("ctrl done", 32'h97, rd);
    chk("live ctrl", 32'h97, {24'h0, battery_select_o, 2'b00, battery_measure_enable_o,
      1'b0, meas_period_o});
    wait_start(50);
    chk("bat start", 32'h1, {31'h0, battery_meas_start_o});
    meas_busy_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    wait_start(40);
    chk("cont held", 32'h0, {31'h0, meas_start_o});
    meas_busy_i <= 1'b0;
    for (int p = 1; p < 7; p++) begin
      wb(1'b1, A_CTL, 4'h1, p);
      idle();
      wait_start(5000);
      wait_start(5000);
      chk("period", (2 ** (3 + p)) * SEC, n);
      chk("bat off", 32'h0, {31'h0, battery_meas_start_o});
      chk("bsel", 32'h0, {31'h0, battery_select_o});
    end
    wb(1'b1, A_CTL, 4'h1, 32'h0);
    idle();
    wait_start(300);
    chk("off", 300, n);
    summarize();
  end
  // whole run is some 10k cycles
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
endmodule : testbench
bind tsc_regs tsc_regs_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .quad_comp_coeff_b_o, .quad_comp_coeff_c_o, .meas_period_o,
  .battery_measure_enable_o, .meas_start_o, .battery_meas_start_o);

// ===== tb/tsc_regs_assertions.sv
/* assertions on the ports of tsc_regs;
   assumes a bind from the testbench top file. */
`timescale 1ns/1ps
`include "tsc_params.svh"
module tsc_regs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [11:0] quad_comp_coeff_b_o,
  input wire logic [11:0] quad_comp_coeff_c_o,
  input wire logic [2:0] meas_period_o,
  input wire logic battery_measure_enable_o,
  input wire logic meas_start_o,
  input wire logic battery_meas_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  a_coeff_b_write: assert property (ack_o && we_i && sel_i[0]
    && adr_i[15:2] == `TSC_IDX_COEFF_B |=> quad_comp_coeff_b_o[7:0] == $past(dat_i[7:0]))
    else $error("coeff b lane 0 not written");
  a_coeff_c_write: assert property (ack_o && we_i && sel_i[1]
    && adr_i[15:2] == `TSC_IDX_COEFF_C |=> quad_comp_coeff_c_o[11:8] == $past(dat_i[11:8]))
    else $error("coeff c lane 1 not written");
  a_bat_with_temp: assert property
    (battery_meas_start_o == (meas_start_o && battery_measure_enable_o))
    else $error("battery start mismatch");
  a_start_no_pair: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse too long");
  a_period_off: assert property
    (meas_period_o == 3'h0 && $past(meas_period_o) == 3'h0 |-> !meas_start_o)
    else $error("start with period off");
  a_read_width: assert property (ack_o && !we_i |-> dat_o[31:13] == 19'h0)
    else $error("read data above field width");
  a_ctrl_spare: assert property (ack_o && !we_i && adr_i[15:2] == `TSC_IDX_CTRL
    |-> dat_o[6:5] == 2'b00) else $error("spare control bits set");
endmodule : tsc_regs_checker
